// ### pkg/ppm_pkg.sv
// ppm_pkg: register map, field positions, modes and states of the parallel port controller
package ppm_pkg;

	// register byte offsets on the apb bus
	localparam int unsigned PADDR_W = 8;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_MODE = 8'h04;
	localparam logic [7:0] OFF_ADDR = 8'h08;
	localparam logic [7:0] OFF_PADEN = 8'h0C;
	localparam logic [7:0] OFF_DATA = 8'h10;
	localparam logic [7:0] OFF_SOUT = 8'h14;
	localparam logic [7:0] OFF_SIN = 8'h18;

	// reset value shared by every register
	localparam logic [15:0] RST_REG16 = 16'h0000;
	localparam logic [31:0] RST_REG32 = 32'h0000_0000;

	// port_control field positions
	localparam int B_ON = 15;
	localparam int B_HALT = 13;
	localparam int B_MUX = 11;
	localparam int B_BEON = 10;
	localparam int B_WRON = 9;
	localparam int B_RDON = 8;
	localparam int B_CSF = 6;
	localparam int B_ALP = 5;
	localparam int B_SELECT_TWO_POLARITY = 4;
	localparam int B_SELECT_ONE_POLARITY = 3;
	localparam int B_BEP = 2;
	localparam int B_WRITE_STROBE_POLARITY = 1;
	localparam int B_READ_STROBE_POLARITY = 0;

	// port_mode_and_waits field positions
	localparam int B_BUSY = 15;
	localparam int B_IRQ_BEHAVIOUR = 13;
	localparam int B_ADDRESS_STEP_MODE = 11;
	localparam int B_WIDE = 10;
	localparam int B_PMODE = 8;
	localparam int B_WB = 6;
	localparam int B_WM = 2;
	localparam int B_WE = 0;

	// port_address field positions
	localparam int B_CS2 = 15;
	localparam int B_CS1 = 14;
	localparam int STEP_W = 11;

	typedef enum logic [1:0] {PM_LEGACY_SLAVE, PM_ADDR_SLAVE, PM_MASTER2, PM_MASTER1} ppm_port_mode_t;
	typedef enum logic [1:0] {MUX_NONE, MUX_LOW, MUX_FULL, MUX_RSVD} ppm_mux_t;
	typedef enum logic [1:0] {CSF_ADDR, CSF_ONE, CSF_BOTH, CSF_RSVD} ppm_csf_t;
	typedef enum logic [1:0] {IRQ_NONE, IRQ_CYCLE, IRQ_STALL, IRQ_BUF3} ppm_irq_t;
	typedef enum logic [1:0] {STEP_NONE, STEP_INC, STEP_DEC, STEP_BUF} ppm_step_t;
	typedef enum logic [2:0] {ST_IDLE, ST_AHI, ST_ALO, ST_SETUP, ST_STROBE, ST_HOLD, ST_GAP} ppm_state_t;

	// whole state of the controller, registered as one word
	typedef struct packed {
		logic [15:0] ctrl;
		logic [15:0] mode;
		logic [15:0] addr;
		logic [15:0] paden;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic [3:0][7:0] sout;
		logic [3:0][7:0] sin;
		ppm_state_t st;
		logic [3:0] cnt;
		logic hi_byte;
		logic is_rd;
		logic [1:0] ptr;
		logic wr_d;
		logic rd_d;
		logic [7:0] d_o;
		logic d_oe;
		logic [15:0] a_o;
		logic [15:0] a_oe;
		logic wr_o;
		logic wr_oe;
		logic rd_o;
		logic rd_oe;
		logic be_o;
		logic be_oe;
		logic irq;
		logic stall;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} ppm_state_s_t;

endpackage : ppm_pkg

// ### design/ppm_top.sv
// ppm_top: configurable 8-bit parallel port, bus master or slave, with apb register access
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module ppm_top (
	// clock and reset
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ppm_pkg::PADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// device power state
	input wire logic idle_i,
	// data pins
	input wire logic [7:0] parallel_data_pins_i,
	output logic [7:0] parallel_data_pins_o,
	output logic parallel_data_pins_oe_o,
	// address pins, selects and latch strobes
	input wire logic [1:0] parallel_addr_pins_i,
	output logic [15:0] parallel_addr_pins_o,
	output logic [15:0] parallel_addr_pins_oe_o,
	// strobes
	input wire logic read_strobe_in_i,
	input wire logic write_strobe_in_i,
	input wire logic chip_select_one_in_i,
	output logic write_strobe_out_o,
	output logic write_strobe_out_oe_o,
	output logic read_strobe_out_o,
	output logic read_strobe_out_oe_o,
	output logic byte_sel_out_o,
	output logic byte_sel_out_oe_o,
	// processor side events
	output logic irq_o,
	output logic stall_o
);
	import ppm_pkg::*;

	ppm_state_s_t q_reg;
	ppm_state_s_t q_next;

	// decoded fields and helpers, all given a value at the top of the process
	logic port_on;
	logic run;
	logic master;
	logic busy;
	logic acc;
	logic wr_acc;
	logic start;
	logic last_byte;
	logic [3:0] wbx;
	logic [3:0] wm;
	logic [15:0] a_full;
	logic [1:0] sidx;
	logic s_cs;
	logic s_rd;
	logic s_wr;
	logic s_evt;
	logic al_hi;
	logic al_lo;
	logic rd_act;
	logic wr_act;
	ppm_mux_t mux;
	ppm_csf_t select_line_function;
	ppm_irq_t irq_behaviour;
	ppm_step_t address_step_mode;
	ppm_port_mode_t pmode;

	//////////////////////////////////////////////////////////////////////
	// next-state logic for the whole controller
	always_comb begin
		q_next = q_reg;
		port_on = q_reg.ctrl[B_ON];
		run = port_on & ~(q_reg.ctrl[B_HALT] & idle_i);
		mux = ppm_mux_t'(q_reg.ctrl[B_MUX +: 2]);
		select_line_function = ppm_csf_t'(q_reg.ctrl[B_CSF +: 2]);
		irq_behaviour = ppm_irq_t'(q_reg.mode[B_IRQ_BEHAVIOUR +: 2]);
		address_step_mode = ppm_step_t'(q_reg.mode[B_ADDRESS_STEP_MODE +: 2]);
		pmode = ppm_port_mode_t'(q_reg.mode[B_PMODE +: 2]);
		master = pmode[1];
		busy = q_reg.st != ST_IDLE;
		wm = q_reg.mode[B_WM +: 4];
		wbx = (wm == 4'h0) ? 4'h0 : {2'b00, q_reg.mode[B_WB +: 2]};
		last_byte = ~(q_reg.mode[B_WIDE] & ~q_reg.hi_byte);
		a_full = q_reg.addr;
		acc = psel_i & penable_i & q_reg.pready;
		wr_acc = acc & pwrite_i;
		start = 1'b0;
		sidx = (pmode == PM_ADDR_SLAVE) ? parallel_addr_pins_i : q_reg.ptr;
		s_cs = (chip_select_one_in_i == q_reg.ctrl[B_SELECT_ONE_POLARITY]);
		s_rd = s_cs & (read_strobe_in_i == q_reg.ctrl[B_READ_STROBE_POLARITY]);
		s_wr = s_cs & (write_strobe_in_i == q_reg.ctrl[B_WRITE_STROBE_POLARITY]);
		s_evt = 1'b0;
		al_hi = 1'b0;
		al_lo = 1'b0;
		rd_act = 1'b0;
		wr_act = 1'b0;
		q_next.irq = 1'b0;

		// apb: answer one cycle into the access phase, registered data
		q_next.pready = psel_i & penable_i & ~q_reg.pready;
		q_next.pslverr = 1'b0;
		q_next.prdata = RST_REG32;
		if (psel_i & penable_i & ~q_reg.pready) begin
			unique case (paddr_i)
				OFF_CTRL: q_next.prdata = {16'h0000, q_reg.ctrl};
				OFF_MODE: q_next.prdata = {16'h0000, busy, q_reg.mode[14:0]};
				OFF_ADDR: q_next.prdata = {16'h0000, q_reg.addr};
				OFF_PADEN: q_next.prdata = {16'h0000, q_reg.paden};
				OFF_DATA: q_next.prdata = {16'h0000, q_reg.rdata};
				OFF_SOUT: q_next.prdata = q_reg.sout;
				OFF_SIN: q_next.prdata = q_reg.sin;
				default: q_next.pslverr = 1'b1;
			endcase
		end

		// register writes; ctrl, mode, address and write data are frozen while a transfer runs
		if (wr_acc) begin
			unique case (paddr_i)
				OFF_CTRL: if (!busy) q_next.ctrl = pwdata_i[15:0];
				OFF_MODE: if (!busy) q_next.mode = {1'b0, pwdata_i[14:0]};
				OFF_ADDR: if (!busy) q_next.addr = pwdata_i[15:0];
				OFF_PADEN: q_next.paden = pwdata_i[15:0];
				OFF_DATA: if (!busy) q_next.wdata = pwdata_i[15:0];
				OFF_SOUT: q_next.sout = pwdata_i;
				default: ;
			endcase
		end
		// a data register access launches a master transfer
		if (acc && paddr_i == OFF_DATA && master && run && !busy) begin
			start = 1'b1;
			q_next.is_rd = ~pwrite_i;
			q_next.hi_byte = 1'b0;
		end

		// master sequencer; frozen in idle halt, dropped when switched off
		if (!port_on) begin
			q_next.st = ST_IDLE;
		end else if (run) begin
			unique case (q_reg.st)
				ST_IDLE: if (start) begin
					q_next.st = ST_GAP;
				end
				ST_AHI: if (q_reg.cnt == 4'h0) begin
					q_next.st = ST_ALO;
					q_next.cnt = wbx;
				end else begin
					q_next.cnt = q_reg.cnt - 4'h1;
				end
				ST_ALO: if (q_reg.cnt == 4'h0) begin
					q_next.st = (wm == 4'h0) ? ST_STROBE : ST_SETUP;
					q_next.cnt = (wm == 4'h0) ? 4'h0 : wbx;
				end else begin
					q_next.cnt = q_reg.cnt - 4'h1;
				end
				ST_SETUP: if (q_reg.cnt == 4'h0) begin
					q_next.st = ST_STROBE;
					q_next.cnt = wm;
				end else begin
					q_next.cnt = q_reg.cnt - 4'h1;
				end
				ST_STROBE: if (q_reg.cnt == 4'h0) begin
					if (q_reg.is_rd) begin
						if (q_reg.hi_byte) q_next.rdata[15:8] = parallel_data_pins_i;
						else q_next.rdata[7:0] = parallel_data_pins_i;
					end
					q_next.st = (wm == 4'h0) ? ST_GAP : ST_HOLD;
					q_next.cnt = {2'b00, q_reg.mode[B_WE +: 2]};
				end else begin
					q_next.cnt = q_reg.cnt - 4'h1;
				end
				ST_HOLD: if (q_reg.cnt == 4'h0) begin
					q_next.st = ST_GAP;
				end else begin
					q_next.cnt = q_reg.cnt - 4'h1;
				end
				ST_GAP: begin
					q_next.st = ST_IDLE;
				end
			endcase
		end
		// the gap ends a byte: go idle, or begin the next byte of a wide word
		if (run && q_reg.st == ST_GAP && !last_byte) begin
			q_next.hi_byte = 1'b1;
			start = 1'b1;
		end else if (run && q_reg.st == ST_GAP) begin
			q_next.irq = (irq_behaviour == IRQ_CYCLE);
			if (address_step_mode == STEP_INC) q_next.addr[STEP_W-1:0] = q_reg.addr[STEP_W-1:0] + 11'h001;
			if (address_step_mode == STEP_DEC) q_next.addr[STEP_W-1:0] = q_reg.addr[STEP_W-1:0] - 11'h001;
		end
		// entry phase of a byte: a start reaches here from idle or from the gap
		if (start && port_on && run) begin
			if (mux == MUX_FULL) begin
				q_next.st = ST_AHI;
				q_next.cnt = wbx;
			end else if (mux == MUX_LOW) begin
				q_next.st = ST_ALO;
				q_next.cnt = wbx;
			end else begin
				q_next.st = (wm == 4'h0) ? ST_STROBE : ST_SETUP;
				q_next.cnt = (wm == 4'h0) ? 4'h0 : {2'b00, q_reg.mode[B_WB +: 2]};
			end
		end

		// slave port: host strobes move bytes through the four buffers
		q_next.wr_d = s_wr & run & ~master;
		q_next.rd_d = s_rd & run & ~master;
		if (run && !master) begin
			if (s_wr && !q_reg.wr_d) begin
				q_next.sin[sidx] = parallel_data_pins_i;
				s_evt = 1'b1;
			end
			if (!s_rd && q_reg.rd_d) s_evt = 1'b1;
			if (s_evt) begin
				if (pmode == PM_LEGACY_SLAVE && address_step_mode == STEP_BUF) q_next.ptr = q_reg.ptr + 2'b01;
				q_next.irq = (irq_behaviour == IRQ_CYCLE) | (irq_behaviour == IRQ_BUF3 && sidx == 2'b11);
			end
		end

		// pin drive, computed from the present state and registered
		al_hi = (q_reg.st == ST_AHI);
		al_lo = (q_reg.st == ST_ALO) | ((q_reg.st == ST_AHI) & (mux == MUX_LOW));
		q_next.a_o = a_full;
		if (select_line_function != CSF_ADDR) q_next.a_o[15] = (busy & q_reg.addr[B_CS2]) ~^ q_reg.ctrl[B_SELECT_TWO_POLARITY];
		if (select_line_function == CSF_BOTH) q_next.a_o[14] = (busy & q_reg.addr[B_CS1]) ~^ q_reg.ctrl[B_SELECT_ONE_POLARITY];
		if (mux != MUX_NONE) q_next.a_o[1:0] = {al_hi ~^ q_reg.ctrl[B_ALP], al_lo ~^ q_reg.ctrl[B_ALP]};
		q_next.a_oe = (port_on & master) ? q_reg.paden : 16'h0000;
		if (!master) q_next.a_oe = 16'h0000;
		// data pins: address phases, write data, or slave read-back
		if (q_reg.st == ST_AHI) q_next.d_o = a_full[15:8];
		else if (q_reg.st == ST_ALO) q_next.d_o = a_full[7:0];
		else if (master) q_next.d_o = q_reg.hi_byte ? q_reg.wdata[15:8] : q_reg.wdata[7:0];
		else q_next.d_o = q_reg.sout[sidx];
		q_next.d_oe = port_on & (master ? (al_hi | al_lo | (~q_reg.is_rd & (q_reg.st == ST_SETUP |
			q_reg.st == ST_STROBE | q_reg.st == ST_HOLD))) : (s_rd & run));
		// strobes: combined read/write plus enable, or separate read and write
		if (pmode == PM_MASTER1) begin
			rd_act = busy & q_reg.is_rd;
			wr_act = (q_reg.st == ST_STROBE);
		end else begin
			rd_act = (q_reg.st == ST_STROBE) & q_reg.is_rd;
			wr_act = (q_reg.st == ST_STROBE) & ~q_reg.is_rd;
		end
		q_next.rd_o = rd_act ~^ q_reg.ctrl[B_READ_STROBE_POLARITY];
		q_next.wr_o = wr_act ~^ q_reg.ctrl[B_WRITE_STROBE_POLARITY];
		q_next.be_o = (busy & q_reg.mode[B_WIDE] & q_reg.hi_byte) ~^ q_reg.ctrl[B_BEP];
		q_next.rd_oe = port_on & master & q_reg.ctrl[B_RDON];
		q_next.wr_oe = port_on & master & q_reg.ctrl[B_WRON];
		q_next.be_oe = port_on & master & q_reg.ctrl[B_BEON];
		q_next.stall = busy & (irq_behaviour == IRQ_STALL);
	end

	//////////////////////////////////////////////////////////////////////
	// the single state register
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			q_reg <= '0;
		end else begin
			q_reg <= q_next;
		end
	end

	// every output comes straight from the state register
	assign prdata_o = q_reg.prdata;
	assign pready_o = q_reg.pready;
	assign pslverr_o = q_reg.pslverr;
	assign parallel_data_pins_o = q_reg.d_o;
	assign parallel_data_pins_oe_o = q_reg.d_oe;
	assign parallel_addr_pins_o = q_reg.a_o;
	assign parallel_addr_pins_oe_o = q_reg.a_oe;
	assign write_strobe_out_o = q_reg.wr_o;
	assign write_strobe_out_oe_o = q_reg.wr_oe;
	assign read_strobe_out_o = q_reg.rd_o;
	assign read_strobe_out_oe_o = q_reg.rd_oe;
	assign byte_sel_out_o = q_reg.be_o;
	assign byte_sel_out_oe_o = q_reg.be_oe;
	assign irq_o = q_reg.irq;
	assign stall_o = q_reg.stall;

	//////////////////////////////////////////////////////////////////////
	// checks: phase lengths are measured by a helper counter of cycles in a state
	// frozen cycles of an idle halt are not counted, so a halted phase keeps its length
	logic [4:0] plen_reg;
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			plen_reg <= 5'h00;
		end else begin
			plen_reg <= (q_next.st != q_reg.st) ? 5'h01 : plen_reg + {4'h0, run};
		end
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);

	property p_off_quiet;
		!$past(q_reg.ctrl[B_ON]) |-> (parallel_data_pins_oe_o == 1'b0 && parallel_addr_pins_oe_o == 16'h0000);
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("port drives pins while switched off");

	property p_setup_len;
		(q_reg.st == ST_SETUP && q_next.st != ST_SETUP && !idle_i) |-> plen_reg == {3'b000, q_reg.mode[B_WB +: 2]} + 5'h01;
	endproperty
	a_setup_len: assert property (p_setup_len) else $error("setup phase length wrong");

	property p_strobe_len;
		(q_reg.st == ST_STROBE && q_next.st != ST_STROBE && q_reg.ctrl[B_ON]) |-> plen_reg == {1'b0, wm} + 5'h01;
	endproperty
	a_strobe_len: assert property (p_strobe_len) else $error("strobe phase length wrong");

	property p_hold_len;
		(q_reg.st == ST_HOLD && q_next.st == ST_GAP) |-> plen_reg == {3'b000, q_reg.mode[B_WE +: 2]} + 5'h01;
	endproperty
	a_hold_len: assert property (p_hold_len) else $error("hold phase length wrong");

	property p_no_wait_skip;
		(q_reg.st == ST_SETUP || q_reg.st == ST_HOLD) |-> wm != 4'h0;
	endproperty
	a_no_wait_skip: assert property (p_no_wait_skip) else $error("setup or hold used with zero strobe wait");

	property p_gap;
		($past(q_reg.st) == ST_STROBE || $past(q_reg.st) == ST_HOLD) && q_reg.st != ST_STROBE
			&& q_reg.st != ST_HOLD && q_reg.ctrl[B_ON]
			|-> q_reg.st == ST_GAP
			##1 write_strobe_out_o == ~q_reg.ctrl[B_WRITE_STROBE_POLARITY];
	endproperty
	a_gap: assert property (p_gap) else $error("no idle cycle between operations");

	property p_busy_read;
		(q_next.pready && !pwrite_i && paddr_i == OFF_MODE) |=> prdata_o[B_BUSY] == $past(q_reg.st != ST_IDLE);
	endproperty
	a_busy_read: assert property (p_busy_read) else $error("busy flag does not follow transfer");

	property p_cycle_irq;
		(q_reg.st == ST_GAP && run && last_byte && irq_behaviour == IRQ_CYCLE) |=> irq_o ##1 !irq_o;
	endproperty
	a_cycle_irq: assert property (p_cycle_irq) else $error("end of cycle interrupt missing");

	property p_addr_step;
		(q_reg.st == ST_GAP && run && last_byte && address_step_mode == STEP_INC) |=>
			q_reg.addr[STEP_W-1:0] == $past(q_reg.addr[STEP_W-1:0]) + 11'h001;
	endproperty
	a_addr_step: assert property (p_addr_step) else $error("address did not step up");

	property p_latch;
		(q_reg.st == ST_ALO && mux != MUX_NONE) |=> parallel_addr_pins_o[0] == q_reg.ctrl[B_ALP]
			&& parallel_data_pins_oe_o && parallel_data_pins_o == $past(q_reg.addr[7:0]);
	endproperty
	a_latch: assert property (p_latch) else $error("address not shown with latch strobe");

endmodule : ppm_top

`default_nettype wire

// ### sim/ppm_periph.sv
// ppm_periph: behavioural external parallel peripheral sitting on the data, strobe and latch pins
`timescale 1ns/1ps
`default_nettype none

module ppm_periph #(
	parameter logic [7:0] RD_BYTE = 8'h3C
) (
	// clock
	input wire logic mclk_i,
	// device side of the data pins
	input wire logic [7:0] dev_d_i,
	input wire logic dev_oe_i,
	// strobes with their active levels
	input wire logic rd_i,
	input wire logic rd_oe_i,
	input wire logic rd_act_i,
	input wire logic wr_i,
	input wire logic wr_oe_i,
	input wire logic wr_act_i,
	input wire logic al_i,
	input wire logic al_oe_i,
	input wire logic al_act_i,
	// resolved data pin level and captured values
	output logic [7:0] data_o,
	output logic [7:0] wr_byte_o,
	output logic [7:0] lat_addr_o
);
	logic rd_on;
	logic wr_on;
	logic al_on;
	logic hold = 1'b0;
	logic [7:0] last = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// strobe decode: a strobe counts only while its pad is driven
	assign rd_on = rd_oe_i && (rd_i == rd_act_i);
	assign wr_on = wr_oe_i && (wr_i == wr_act_i);
	assign al_on = al_oe_i && (al_i == al_act_i);

	// read data held one cycle past the strobe, then the bus floats to a changing value
	always_comb begin
		if (dev_oe_i)
			data_o = dev_d_i;
		else if (rd_on || hold)
			data_o = RD_BYTE;
		else
			data_o = ~last;
	end

	// capture written bytes and the latched address
	always_ff @(posedge mclk_i) begin
		hold <= rd_on;
		last <= data_o;
		if (wr_on && dev_oe_i)
			wr_byte_o <= dev_d_i;
		if (al_on && dev_oe_i)
			lat_addr_o <= dev_d_i;
	end
endmodule : ppm_periph

`default_nettype wire

// ### sim/testbench.sv
// testbench: apb driven tests of the parallel port controller against a peripheral model
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import ppm_pkg::*;
	logic mclk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, idle_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0000_0000;
	logic [31:0] prdata_o, rdv;
	logic pready_o, pslverr_o, erv, wr_prev;
	logic [7:0] parallel_data_pins_i, parallel_data_pins_o, wr_byte, lat_addr;
	logic [15:0] parallel_addr_pins_o, parallel_addr_pins_oe_o;
	logic parallel_data_pins_oe_o, write_strobe_out_o, write_strobe_out_oe_o, read_strobe_out_o;
	logic read_strobe_out_oe_o, byte_sel_out_o, byte_sel_out_oe_o, irq_o, stall_o;
	logic wr_act = 1'b0, rd_act = 1'b0, al_act = 1'b0;
	int num_errors = 0, tests_run = 0;
	int wr_cnt, wr_rise, rd_cnt, be_cnt, irq_cnt;

	// slave-side host inputs are tied: this bench covers the master modes
	ppm_top i_ppm_top (.mclk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
		.prdata_o, .pready_o, .pslverr_o, .idle_i, .parallel_data_pins_i, .parallel_data_pins_o,
		.parallel_data_pins_oe_o, .parallel_addr_pins_i(2'b00), .parallel_addr_pins_o,
		.parallel_addr_pins_oe_o, .read_strobe_in_i(1'b1), .write_strobe_in_i(1'b1),
		.chip_select_one_in_i(1'b0), .write_strobe_out_o, .write_strobe_out_oe_o, .read_strobe_out_o,
		.read_strobe_out_oe_o, .byte_sel_out_o, .byte_sel_out_oe_o, .irq_o, .stall_o);

	ppm_periph i_ppm_periph (.mclk_i, .dev_d_i(parallel_data_pins_o), .dev_oe_i(parallel_data_pins_oe_o),
		.rd_i(read_strobe_out_o), .rd_oe_i(read_strobe_out_oe_o), .rd_act_i(rd_act),
		.wr_i(write_strobe_out_o), .wr_oe_i(write_strobe_out_oe_o), .wr_act_i(wr_act),
		.al_i(parallel_addr_pins_o[0]), .al_oe_i(parallel_addr_pins_oe_o[0]), .al_act_i(al_act),
		.data_o(parallel_data_pins_i), .wr_byte_o(wr_byte), .lat_addr_o(lat_addr));

	initial begin
		forever #12.5 mclk_i = ~mclk_i;
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin monitor on the falling edge, where registered pins are settled
	always @(negedge mclk_i) begin
		if (write_strobe_out_oe_o === 1'b1 && write_strobe_out_o === wr_act) begin
			wr_cnt++;
			if (!wr_prev)
				wr_rise++;
			wr_prev = 1'b1;
		end else
			wr_prev = 1'b0;
		if (read_strobe_out_oe_o === 1'b1 && read_strobe_out_o === rd_act)
			rd_cnt++;
		if (byte_sel_out_oe_o === 1'b1 && byte_sel_out_o === 1'b0)
			be_cnt++;
		if (irq_o === 1'b1)
			irq_cnt++;
	end

	task end_sim;
		$display("counts: %0d compares, %0d mismatches", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim

	task chk(input string n, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", n, exp, got);
		end
	endtask : chk

	// one apb transfer; request held until pready is sampled high at a rising edge
	task bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd, output logic e);
		int n;
		n = 0;
		@(posedge mclk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= wd;
		@(posedge mclk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge mclk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 50);
		if (pready_o !== 1'b1) begin
			num_errors++;
			$display("unexpected pready: expected 1, seen %b", pready_o);
		end
		rd = prdata_o;
		e = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : bus

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		logic y;
		bus(1'b1, a, d, x, y);
	endtask : wr

	// poll the busy flag under a bound
	task wait_idle;
		int n;
		n = 0;
		do begin
			bus(1'b0, OFF_MODE, 32'h0, rdv, erv);
			n++;
		end while (rdv[B_BUSY] !== 1'b0 && n < 200);
		chk("transfer finished", 32'h1, {31'h0, n < 200});
	endtask : wait_idle

	// config writes are only safe while idle, so every test after the reset check starts here
	task cfg(input logic [15:0] c, input logic [15:0] m, input logic [15:0] ad);
		wr(OFF_CTRL, {16'h0000, c});
		wr(OFF_MODE, {16'h0000, m});
		wr(OFF_ADDR, {16'h0000, ad});
		wr_cnt = 0;
		wr_rise = 0;
		rd_cnt = 0;
		be_cnt = 0;
		irq_cnt = 0;
	endtask : cfg

	initial begin
		repeat (20000) @(posedge mclk_i);
		num_errors++;
		end_sim();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		// reset values and an unmapped word
		for (int i = 0; i < 4; i++) begin
			bus(1'b0, 8'(4 * i), 32'h0, rdv, erv);
			chk("register reset value", 32'h0000_0000, rdv);
		end
		bus(1'b0, 8'h1C, 32'h0, rdv, erv);
		chk("unmapped error", 32'h0000_0001, {31'h0, erv});
		$display("test reset done");
		wr(OFF_PADEN, 32'h0000_FFFF);
		// port off: data write must not reach the pins
		cfg(16'h0300, 16'h0204, 16'h0000);
		wr(OFF_DATA, 32'h0000_0055);
		repeat (20) @(posedge mclk_i);
		chk("strobe cycles while off", 32'h0, 32'(wr_cnt));
		$display("test off done");
		// master 2 write, strobe wait 1, irq per cycle, increment
		cfg(16'h8300, 16'h2A04, 16'h0005);
		wr(OFF_DATA, 32'h0000_00A5);
		bus(1'b0, OFF_MODE, 32'h0, rdv, erv);
		chk("busy during transfer", 32'h1, {31'h0, rdv[B_BUSY]});
		wait_idle();
		chk("write strobe cycles", 32'h2, 32'(wr_cnt));
		chk("irq pulses", 32'h1, 32'(irq_cnt));
		chk("written byte", 32'hA5, {24'h0, wr_byte});
		bus(1'b0, OFF_ADDR, 32'h0, rdv, erv);
		chk("address after step", 32'h0006, rdv);
		$display("test write done");
		// wide word, zero strobe wait so the long setup and hold are skipped, decrement, no irq
		cfg(16'h8700, 16'h16C3, 16'h0006);
		wr(OFF_DATA, 32'h0000_1234);
		wait_idle();
		chk("strobe pulses", 32'h2, 32'(wr_rise));
		chk("strobe cycles", 32'h2, 32'(wr_cnt));
		chk("byte select seen", 32'h1, {31'h0, be_cnt > 0});
		chk("irq pulses", 32'h0, 32'(irq_cnt));
		chk("last byte", 32'h12, {24'h0, wr_byte});
		bus(1'b0, OFF_ADDR, 32'h0, rdv, erv);
		chk("address after step", 32'h0005, rdv);
		$display("test wide done");
		// master 1 read with active-high strobes, strobe wait 2
		wr_act = 1'b1;
		rd_act = 1'b1;
		cfg(16'h8303, 16'h0308, 16'h0000);
		bus(1'b0, OFF_DATA, 32'h0, rdv, erv);
		wait_idle();
		chk("enable strobe cycles", 32'h3, 32'(wr_cnt));
		chk("read line active", 32'h1, {31'h0, rd_cnt > 0});
		bus(1'b0, OFF_DATA, 32'h0, rdv, erv);
		chk("read data", 32'h0000_003C, rdv);
		wait_idle();
		$display("test read done");
		// partly multiplexed address with active-high latch strobe
		wr_act = 1'b0;
		rd_act = 1'b0;
		al_act = 1'b1;
		cfg(16'h8B20, 16'h0204, 16'h0177);
		wr(OFF_DATA, 32'h0000_00C3);
		wait_idle();
		chk("latched address", 32'h77, {24'h0, lat_addr});
		chk("written byte", 32'hC3, {24'h0, wr_byte});
		// fully multiplexed address: only the low byte rides the low latch strobe
		cfg(16'h9320, 16'h0204, 16'h0155);
		wr(OFF_DATA, 32'h0000_0096);
		wait_idle();
		chk("latched low address", 32'h55, {24'h0, lat_addr});
		chk("written byte", 32'h96, {24'h0, wr_byte});
		$display("test mux done");
		// halt in idle freezes a long transfer; stall mode and chip select two on
		cfg(16'hA380, 16'h423C, 16'h8000);
		wr(OFF_DATA, 32'h0000_005A);
		idle_i <= 1'b1;
		repeat (60) @(posedge mclk_i);
		bus(1'b0, OFF_MODE, 32'h0, rdv, erv);
		chk("busy while halted", 32'h1, {31'h0, rdv[B_BUSY]});
		chk("stall while busy", 32'h1, {31'h0, stall_o});
		chk("select pins while busy", 32'h1, {30'h0, parallel_addr_pins_o[15:14]});
		idle_i <= 1'b0;
		wait_idle();
		chk("one strobe pulse", 32'h1, 32'(wr_rise));
		chk("written byte", 32'h5A, {24'h0, wr_byte});
		chk("stall after transfer", 32'h0, {31'h0, stall_o});
		chk("select pins when idle", 32'h3, {30'h0, parallel_addr_pins_o[15:14]});
		$display("test halt done");
		end_sim();
	end
endmodule : testbench

`default_nettype wire
